// *** rtl/nvseq_map.svh ***
`ifndef NVSEQ_MAP_SVH
`define NVSEQ_MAP_SVH
// command sequence addresses
`define NVSEQ_ADDR_1          16'h4e38
`define NVSEQ_ADDR_2          16'hb1c7
`define NVSEQ_ADDR_3          16'h83e0
`define NVSEQ_ADDR_4          16'h7c1f
`define NVSEQ_ADDR_5          16'h703f
`define NVSEQ_ADDR_STORE      16'h8fc0
`define NVSEQ_ADDR_RECALL     16'h4c63
`define NVSEQ_ADDR_AS_DIS     16'h8b45
`define NVSEQ_ADDR_AS_EN      16'h4b46
// compared address field
`define NVSEQ_CMP_MSB         14
`define NVSEQ_CMP_LSB         2
// access timing, ns
`define NVSEQ_T_ADDR_SETUP_NS 50
`define NVSEQ_T_STROBE_NS     100
`define NVSEQ_T_RECOVER_NS    50
`define NVSEQ_CLK_NS          25
`define NVSEQ_SETUP_CYC  ((`NVSEQ_T_ADDR_SETUP_NS + `NVSEQ_CLK_NS - 1) / `NVSEQ_CLK_NS)
`define NVSEQ_STROBE_CYC ((`NVSEQ_T_STROBE_NS + `NVSEQ_CLK_NS - 1) / `NVSEQ_CLK_NS)
`define NVSEQ_RECOV_CYC  ((`NVSEQ_T_RECOVER_NS + `NVSEQ_CLK_NS - 1) / `NVSEQ_CLK_NS)
`endif

// *** rtl/nvseq_pkg.sv ***
package nvseq_pkg;
  typedef enum logic [1:0] {
    NVSEQ_CMD_STORE  = 2'h0,
    NVSEQ_CMD_RECALL = 2'h1,
    NVSEQ_CMD_AS_DIS = 2'h2,
    NVSEQ_CMD_AS_EN  = 2'h3
  } nvseq_cmd_t;
  typedef enum logic [2:0] {
    NVSEQ_IDLE   = 3'b000,
    NVSEQ_SETUP  = 3'b001,
    NVSEQ_STROBE = 3'b011,
    NVSEQ_RECOV  = 3'b010,
    NVSEQ_BUSY   = 3'b110
  } nvseq_st_t;
endpackage : nvseq_pkg

// *** rtl/nvseq_host.sv ***
`timescale 1ns/1ps
`include "nvseq_map.svh"
// Behaviour
// - store: read 4e38, b1c7, 83e0, 7c1f, 703f, 8fc0 in order
// - any other access inside the six aborts; host never interleaves
// - host strobes reads by chip select, keeps write enable high
// - after auto-store setting change with persist set host issues a store
module nvseq_host
  import nvseq_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  input  wire logic              cmd_valid,
  input  wire nvseq_pkg::nvseq_cmd_t cmd,
  input  wire logic              persist,
  output logic                   cmd_ready,
  output logic                   cmd_done,
  output logic [19:0]            addr,
  output logic                   chip_sel_n,
  output logic                   out_en_n,
  output logic                   write_en_n,
  output logic                   upper_byte_sel_n,
  output logic                   lower_byte_sel_n,
  input  wire logic              store_busy_n_i,
  output logic                   store_busy_n_o,
  output logic                   store_busy_n_oe
);
  import nvseq_pkg::*;

  // ************************************************************
  // address table
  // ************************************************************
  function automatic logic [15:0] seq_addr(input logic [2:0] idx, input nvseq_cmd_t c);
    logic [15:0] a;
    a = 16'h0000;
    unique case (idx)
      3'h0: a = `NVSEQ_ADDR_1;
      3'h1: a = `NVSEQ_ADDR_2;
      3'h2: a = `NVSEQ_ADDR_3;
      3'h3: a = `NVSEQ_ADDR_4;
      3'h4: a = `NVSEQ_ADDR_5;
      default: begin
        unique case (c)
          NVSEQ_CMD_STORE:  a = `NVSEQ_ADDR_STORE;
          NVSEQ_CMD_RECALL: a = `NVSEQ_ADDR_RECALL;
          NVSEQ_CMD_AS_DIS: a = `NVSEQ_ADDR_AS_DIS;
          NVSEQ_CMD_AS_EN:  a = `NVSEQ_ADDR_AS_EN;
        endcase
      end
    endcase
    return a;
  endfunction : seq_addr

  // ************************************************************
  // sequencer
  // ************************************************************
  nvseq_st_t   st_q, st_d;
  nvseq_cmd_t  cmd_q, cmd_d;
  logic [2:0]  idx_q, idx_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        pend_q, pend_d;
  logic        done_q, done_d;
  logic [19:0] addr_q, addr_d;
  logic        cs_q, cs_d;
  logic [15:0] seq_a;

  always_comb begin
    st_d   = st_q;
    cmd_d  = cmd_q;
    idx_d  = idx_q;
    cnt_d  = cnt_q;
    pend_d = pend_q;
    done_d = 1'b0;
    addr_d = addr_q;
    cs_d   = 1'b1;
    // sequence address of the read in progress
    seq_a  = seq_addr(idx_q, cmd_q);
    unique case (st_q)
      NVSEQ_IDLE: begin
        // wait until the device is not busy before starting
        if (pend_q && store_busy_n_i) begin
          cmd_d  = NVSEQ_CMD_STORE;
          pend_d = 1'b0;
          idx_d  = 3'h0;
          cnt_d  = 3'h0;
          st_d   = NVSEQ_SETUP;
        end else if (cmd_valid && store_busy_n_i) begin
          cmd_d  = cmd;
          pend_d = persist && (cmd == NVSEQ_CMD_AS_DIS || cmd == NVSEQ_CMD_AS_EN);
          idx_d  = 3'h0;
          cnt_d  = 3'h0;
          st_d   = NVSEQ_SETUP;
        end
      end
      NVSEQ_SETUP: begin
        // bits outside 14..2 are don't care to the device, kept zero
        addr_d = {5'h00, seq_a[`NVSEQ_CMP_MSB:`NVSEQ_CMP_LSB], 2'h0};
        cnt_d  = cnt_q + 3'h1;
        if (cnt_q == 3'(`NVSEQ_SETUP_CYC - 1)) begin
          cnt_d = 3'h0;
          st_d  = NVSEQ_STROBE;
        end
      end
      NVSEQ_STROBE: begin
        cs_d  = 1'b0;
        cnt_d = cnt_q + 3'h1;
        // last strobe cycle stays low; recovery raises the strobe
        if (cnt_q == 3'(`NVSEQ_STROBE_CYC - 1)) begin
          cnt_d = 3'h0;
          st_d  = NVSEQ_RECOV;
        end
      end
      NVSEQ_RECOV: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'(`NVSEQ_RECOV_CYC - 1)) begin
          cnt_d = 3'h0;
          if (idx_q == 3'h5) begin
            st_d = NVSEQ_BUSY;
          end else begin
            idx_d = idx_q + 3'h1;
            st_d  = NVSEQ_SETUP;
          end
        end
      end
      NVSEQ_BUSY: begin
        // device may pull busy low during store or recall; wait for release
        if (store_busy_n_i) begin
          done_d = 1'b1;
          st_d   = NVSEQ_IDLE;
        end
      end
      default: st_d = NVSEQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_q   <= NVSEQ_IDLE;
      cmd_q  <= NVSEQ_CMD_STORE;
      idx_q  <= 3'h0;
      cnt_q  <= 3'h0;
      pend_q <= 1'b0;
      done_q <= 1'b0;
      addr_q <= 20'h00000;
      cs_q   <= 1'b1;
    end else if (clk_en) begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      idx_q  <= idx_d;
      cnt_q  <= cnt_d;
      pend_q <= pend_d;
      done_q <= done_d;
      addr_q <= addr_d;
      cs_q   <= cs_d;
    end
  end

  // ************************************************************
  // pins
  // ************************************************************
  logic rdy_q, rdy_d;
  always_comb begin
    rdy_d = (st_d == NVSEQ_IDLE) && !pend_d && store_busy_n_i;
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdy_q <= 1'b0;
    end else if (clk_en) begin
      rdy_q <= rdy_d;
    end
  end

  // ************************************************************
  // static pin levels
  // ************************************************************
  // reads are strobed by chip select alone, so output enable and both
  // byte selects stay active; the host never writes and never pulls busy
  logic oe_n_q, we_n_q, ub_n_q, lb_n_q, bs_o_q, bs_oe_q;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      oe_n_q  <= 1'b0;
      we_n_q  <= 1'b1;
      ub_n_q  <= 1'b0;
      lb_n_q  <= 1'b0;
      bs_o_q  <= 1'b1;
      bs_oe_q <= 1'b0;
    end
  end

  assign cmd_ready        = rdy_q;
  assign cmd_done         = done_q;
  assign addr             = addr_q;
  assign chip_sel_n       = cs_q;
  assign out_en_n         = oe_n_q;
  assign write_en_n       = we_n_q;
  assign upper_byte_sel_n = ub_n_q;
  assign lower_byte_sel_n = lb_n_q;
  assign store_busy_n_o   = bs_o_q;
  assign store_busy_n_oe  = bs_oe_q;
endmodule : nvseq_host

// *** tb/nvseq_host_asserts.sv ***
`timescale 1ns/1ps
module nvseq_host_asserts (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [19:0] addr,
  input wire logic        chip_sel_n,
  input wire logic        write_en_n,
  input wire logic        store_busy_n_i
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_write_held_high: assert property (write_en_n)
    else $error("write enable low");
  a_quiet_busy: assert property (!store_busy_n_i |-> chip_sel_n)
    else $error("strobe while busy");
  a_addr_hold: assert property (!chip_sel_n && $past(!chip_sel_n) |-> $stable(addr))
    else $error("address moved in strobe");
  a_strobe_width: assert property ($fell(chip_sel_n) |-> !chip_sel_n[*4] ##1 chip_sel_n)
    else $error("strobe width wrong");
endmodule : nvseq_host_asserts
bind nvseq_host nvseq_host_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .addr(addr),
  .chip_sel_n(chip_sel_n), .write_en_n(write_en_n), .store_busy_n_i(store_busy_n_i));

// *** tb/nvseq_dev.sv ***
`timescale 1ns/1ps
module nvseq_dev #(parameter int PWR = 30, parameter int BSY = 12) (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic [19:0] addr,
  input wire logic        chip_sel_n,
  input wire logic        write_en_n,
  output logic            busy_low,
  output logic [1:0]      last_cmd,
  output int              n_cmd,
  output logic            as_en
);
  logic [15:0] seq [9] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f,
                           16'h8fc0, 16'h4c63, 16'h8b45, 16'h4b46};
  logic cs_q = 1'b1;
  int idx, cnt;
  initial begin
    n_cmd = 0;
    last_cmd = 2'h0;
    as_en = 1'b1;
  end
  always @(posedge mclk) begin
    cs_q <= chip_sel_n;
    if (!rst_b) begin
      cnt <= PWR;
      idx <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (chip_sel_n && !cs_q) begin
      if (!write_en_n) idx <= 0;
      else if (idx < 5) idx <= (seq[idx][14:2] == addr[14:2]) ? idx + 1 : 0;
      else begin
        idx <= 0;
        for (int k = 5; k < 9; k++) begin
          if (seq[k][14:2] == addr[14:2]) begin
            last_cmd <= 2'(k - 5);
            n_cmd <= n_cmd + 1;
            cnt <= (k < 7) ? BSY : 0;
            if (k > 6) as_en <= (k == 8);
          end
        end
      end
    end
  end
  assign busy_low = cnt > 0;
endmodule : nvseq_dev

// *** tb/tb_nvseq_host.sv ***
`timescale 1ns/1ps
module tb_nvseq_host;
  import nvseq_pkg::*;
  logic mclk, rst_b, clk_en, cmd_valid, persist, cmd_ready, cmd_done;
  logic chip_sel_n, out_en_n, write_en_n, bs_o, bs_oe, busy_low, as_en, ub_n, lb_n;
  logic [19:0] addr;
  logic [1:0]  last_cmd;
  nvseq_cmd_t  cmd;
  int n_cmd, errors, checked;
  wire busy_n = !(busy_low || (bs_oe && !bs_o));
  nvseq_host DUT (.mclk, .rst_b, .clk_en, .cmd_valid, .cmd, .persist, .cmd_ready,
    .cmd_done, .addr, .chip_sel_n, .out_en_n, .write_en_n, .upper_byte_sel_n(ub_n),
    .lower_byte_sel_n(lb_n), .store_busy_n_i(busy_n), .store_busy_n_o(bs_o),
    .store_busy_n_oe(bs_oe));
  nvseq_dev PEER (.mclk, .rst_b, .addr, .chip_sel_n, .write_en_n, .busy_low,
    .last_cmd, .n_cmd, .as_en);
  initial begin
    mclk = 0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic run(input nvseq_cmd_t c, input logic p, input int nc, input logic [1:0] lc);
    int n0;
    logic d;
    n0 = n_cmd;
    d = 0;
    while (cmd_ready !== 1'b1) begin
      @(posedge mclk);
      #2;
    end
    cmd = c;
    persist = p;
    cmd_valid = 1;
    @(posedge mclk);
    #2 cmd_valid = 0;
    repeat (900) begin
      @(posedge mclk);
      #2 d = d | (cmd_done === 1'b1);
      if (d && cmd_ready === 1'b1) break;
    end
    chk(d, 1);
    chk(32'(n_cmd - n0), nc);
    chk(last_cmd, lc);
  endtask : run
  task automatic t_powerup;
    repeat (3) @(posedge mclk);
    #2 chk(cmd_ready, 0);
    chk(as_en, 1);
    chk(out_en_n, 0);
    chk(write_en_n, 1);
    chk({ub_n, lb_n}, 2'h0);
    chk(bs_oe, 0);
  endtask : t_powerup
  task automatic t_store;
    run(NVSEQ_CMD_STORE, 0, 1, 2'h0);
    chk({addr[19:15], addr[1:0]}, 7'h00);
  endtask : t_store
  task automatic t_recall;
    run(NVSEQ_CMD_RECALL, 0, 1, 2'h1);
  endtask : t_recall
  task automatic t_as_dis;
    run(NVSEQ_CMD_AS_DIS, 0, 1, 2'h2);
    chk(as_en, 0);
  endtask : t_as_dis
  task automatic t_as_en;
    run(NVSEQ_CMD_AS_EN, 0, 1, 2'h3);
    chk(as_en, 1);
  endtask : t_as_en
  task automatic t_persist;
    run(NVSEQ_CMD_AS_DIS, 1, 2, 2'h0);
    chk(as_en, 0);
    run(NVSEQ_CMD_AS_EN, 1, 2, 2'h0);
    chk(as_en, 1);
  endtask : t_persist
  initial begin
    #100us;
    errors++;
    conclude();
  end
  initial begin
    rst_b = 0;
    clk_en = 1;
    cmd_valid = 0;
    persist = 0;
    cmd = NVSEQ_CMD_STORE;
    repeat (10) @(posedge mclk);
    #2 rst_b = 1;
    t_powerup();
    t_store();
    t_recall();
    t_as_dis();
    t_as_en();
    t_persist();
    conclude();
  end
endmodule : tb_nvseq_host
